/* rtl/rsp_cfg.svh */
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// ==========================================================================
// Register byte addresses and word indices.
`define RSP_ADDR_STRAP      8'h00
`define RSP_ADDR_MODE       8'h04
`define RSP_IDX_INT_CTRL    8'h1b
`define RSP_IDX_PHY_CTRL    8'h1f
`define RSP_ADDR_INT_CTRL   8'h6c
`define RSP_ADDR_PHY_CTRL   8'h7c

// ==========================================================================
// Field positions.
`define RSP_STRAP_DUPLEX    0
`define RSP_STRAP_MODE2     1
`define RSP_STRAP_BCAST_DIS 2
`define RSP_STRAP_ISOLATE   3
`define RSP_STRAP_FAULT_N   4
`define RSP_STRAP_WAKE_SEL  5
`define RSP_STRAP_WAKE_FLAG 8
`define RSP_STRAP_VALID     9
`define RSP_MODE_CLK50      0
`define RSP_INT_EN_LSB      8
`define RSP_PHY_IRQ_HIGH    9

// ==========================================================================
// Reset values.
`define RSP_MODE_RST        1'b0
`define RSP_INT_EN_RST      8'h00
`define RSP_IRQ_HIGH_RST    1'b0

// ==========================================================================
// Timing.
`define RSP_CORE_CLK_HZ     200000000
`define RSP_REF_CLK_HZ      50000000
`define RSP_REF_HALF_CYC    (`RSP_CORE_CLK_HZ / (2 * `RSP_REF_CLK_HZ))

`endif

/* rtl/rsp_pkg.sv */
package rsp_pkg;

   // Strap capture sequence, Gray coded along the path.
   typedef enum logic [1:0] {
      RSP_HOLD    = 2'b00,
      RSP_CAPTURE = 2'b01,
      RSP_RUN     = 2'b11
   } rsp_state_t;

   typedef logic [7:0] rsp_evt_t;

endpackage

/* rtl/rsp_pin_if.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Requests and pin drive of the shared interrupt and wake pin.
interface rsp_pin_if;
   logic irq_req;
   logic wake_req;
   logic active_high;
   logic wake_mode;
   logic run;
   logic pin_out;
   logic pin_oe_n;

   modport ctrl (output irq_req, output wake_req, output active_high,
                 output wake_mode, output run, input pin_out, input pin_oe_n);
   modport drv  (input irq_req, input wake_req, input active_high,
                 input wake_mode, input run, output pin_out, output pin_oe_n);
endinterface

`default_nettype wire

/* rtl/rsp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Two-stage synchroniser, one per pin bit.
module rsp_sync (
   input  wire logic       core_clk,
   input  wire logic [5:0] async_in,
   output logic      [5:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_bit
         logic meta;
         // No reset, so pin levels keep flowing while the chip is in reset.
         always_ff @(posedge core_clk) begin
            meta        <= async_in[i];
            sync_out[i] <= meta;
         end
      end
   endgenerate
endmodule

`default_nettype wire

/* rtl/rsp_irq_pin.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Open-drain driver of the shared interrupt and wake pin.
module rsp_irq_pin (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   rsp_pin_if.drv    pin
);
   logic pull_low;

   // Wake mode pulls low on a wake event; interrupt mode pulls low on a request when
   // the active level is low, or while idle when the active level is high.
   assign pull_low = pin.wake_mode ? pin.wake_req
                                   : (pin.irq_req ^ pin.active_high);

   // The pin is only ever pulled low or released to its pull-up.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin.pin_oe_n <= 1'b1;
      end else begin
         pin.pin_oe_n <= ~(pin.run & pull_low);
      end
   end
   assign pin.pin_out = 1'b0;
endmodule

`default_nettype wire

/* rtl/rsp_top.sv */
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rsp_cfg.svh"

module rsp_top (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // AXI4-Lite slave.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Receive path from the PHY core.
   input  wire logic        rx_data0,
   input  wire logic        rx_crs_dv,
   input  wire logic        rx_error,
   input  wire logic [7:0]  int_event,
   input  wire logic        wol_event,
   // Dual-use pins.
   input  wire logic        rxd0_pin_in,
   output logic             rxd0_pin_out,
   output logic             rxd0_pin_oe_n,
   input  wire logic        crs_dv_pin_in,
   output logic             crs_dv_pin_out,
   output logic             crs_dv_pin_oe_n,
   input  wire logic        ref_clk_pin_in,
   output logic             ref_clk_pin_out,
   output logic             ref_clk_pin_oe_n,
   input  wire logic        rxer_pin_in,
   output logic             rxer_pin_out,
   output logic             rxer_pin_oe_n,
   input  wire logic        interrupt_request_pin_in,
   output logic             interrupt_request_pin_out,
   output logic             interrupt_request_pin_oe_n,
   input  wire logic        wake_sel_pin_in
);

   // ========================================================================
   // Pin synchronisers and strap capture.
   logic [5:0]          pin_sync;
   logic [5:0]          strap;
   logic                strap_valid;
   rsp_pkg::rsp_state_t state;
   rsp_pkg::rsp_state_t next_state;
   logic                run;

   rsp_sync u_sync (
      .core_clk (core_clk),
      .async_in ({wake_sel_pin_in, interrupt_request_pin_in, rxer_pin_in,
                  ref_clk_pin_in, crs_dv_pin_in, rxd0_pin_in}),
      .sync_out (pin_sync)
   );

   // Reset holds the sequence; the second cycle after release captures.
   always_comb begin
      unique case (state)
         rsp_pkg::RSP_HOLD:    next_state = rsp_pkg::RSP_CAPTURE;
         rsp_pkg::RSP_CAPTURE: next_state = rsp_pkg::RSP_RUN;
         rsp_pkg::RSP_RUN:     next_state = rsp_pkg::RSP_RUN;
         default:              next_state = rsp_pkg::RSP_HOLD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= rsp_pkg::RSP_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Straps load once per reset and hold until the next one.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strap       <= 6'h00;
         strap_valid <= 1'b0;
      end else if (state == rsp_pkg::RSP_CAPTURE) begin
         strap       <= pin_sync;
         strap_valid <= 1'b1;
      end
   end

   assign run = (state == rsp_pkg::RSP_RUN);

   // ========================================================================
   // Registers.
   logic       clk50_mode;
   logic [7:0] int_en;
   rsp_pkg::rsp_evt_t int_stat;
   logic       irq_high;
   logic       wake_flag;

   // ========================================================================
   // AXI4-Lite write channel.
   logic [7:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic        wr_do;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic        wr_strap;
   logic        wr_mode;
   logic        wr_int;
   logic        wr_phy;
   logic        wr_hit;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_do         = aw_held & w_held & ~s_axi_bvalid;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_strb
         assign wmask[b*8 +: 8] = {8{w_strb[b]}};
      end
   endgenerate
   assign wval = w_data & wmask;

   // Write decode.
   assign wr_strap = wr_do & (aw_addr == `RSP_ADDR_STRAP);
   assign wr_mode  = wr_do & (aw_addr == `RSP_ADDR_MODE);
   assign wr_int   = wr_do & (aw_addr == `RSP_ADDR_INT_CTRL);
   assign wr_phy   = wr_do & (aw_addr == `RSP_ADDR_PHY_CTRL);
   assign wr_hit   = wr_strap | wr_mode | wr_int | wr_phy;

   // Address and data are held until both have arrived.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_do) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response, error for an unmapped address.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ========================================================================
   // AXI4-Lite read channel.
   logic        rd_take;
   logic        rd_int_clr;
   logic        rd_hit;
   logic [31:0] rd_mux;

   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_take       = s_axi_arvalid & s_axi_arready;
   assign rd_int_clr    = rd_take & (s_axi_araddr == `RSP_ADDR_INT_CTRL);
   assign rd_hit        = (s_axi_araddr == `RSP_ADDR_STRAP) | (s_axi_araddr == `RSP_ADDR_MODE) |
                          (s_axi_araddr == `RSP_ADDR_INT_CTRL) |
                          (s_axi_araddr == `RSP_ADDR_PHY_CTRL);

   // Read selection; unmapped and reserved bits read as zero.
   assign rd_mux = (s_axi_araddr == `RSP_ADDR_STRAP) ?
                      {22'h00_0000, strap_valid, wake_flag, 2'b00, strap} :
                   (s_axi_araddr == `RSP_ADDR_MODE) ? {31'h0000_0000, clk50_mode} :
                   (s_axi_araddr == `RSP_ADDR_INT_CTRL) ? {16'h0000, int_en, int_stat} :
                   (s_axi_araddr == `RSP_ADDR_PHY_CTRL) ? {22'h00_0000, irq_high, 9'h000} :
                   32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ========================================================================
   // Control registers and sticky status.
   rsp_pkg::rsp_evt_t next_int_stat;
   logic              next_wake_flag;

   // A new event wins over a clear in the same cycle.
   assign next_int_stat  = (int_stat & ~{8{rd_int_clr}}) | int_event;
   assign next_wake_flag = (wake_flag & ~(wr_strap & wval[`RSP_STRAP_WAKE_FLAG])) |
                           wol_event;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk50_mode <= `RSP_MODE_RST;
         int_en     <= `RSP_INT_EN_RST;
         irq_high   <= `RSP_IRQ_HIGH_RST;
         int_stat   <= 8'h00;
         wake_flag  <= 1'b0;
      end else begin
         int_stat  <= next_int_stat;
         wake_flag <= next_wake_flag;
         if (wr_mode & w_strb[0]) begin
            clk50_mode <= wval[`RSP_MODE_CLK50];
         end
         if (wr_int & w_strb[1]) begin
            int_en <= wval[`RSP_INT_EN_LSB +: 8];
         end
         if (wr_phy & w_strb[1]) begin
            irq_high <= wval[`RSP_PHY_IRQ_HIGH];
         end
      end
   end

   // ========================================================================
   // Interrupt and wake pin.
   rsp_pin_if pin_bus ();

   assign pin_bus.irq_req     = |(int_stat & int_en);
   assign pin_bus.wake_req    = wake_flag;
   assign pin_bus.active_high = irq_high;
   assign pin_bus.wake_mode   = strap[`RSP_STRAP_WAKE_SEL];
   assign pin_bus.run         = run;

   rsp_irq_pin u_irq_pin (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .pin      (pin_bus.drv)
   );

   assign interrupt_request_pin_out  = pin_bus.pin_out;
   assign interrupt_request_pin_oe_n = pin_bus.pin_oe_n;

   // ========================================================================
   // Reference clock divider; the falling phase gives the data update tick.
   logic [1:0] ref_cnt;
   logic       ref_lvl;
   logic       ref_wrap;
   logic       rmii_tick;

   assign ref_wrap  = (ref_cnt == 2'(`RSP_REF_HALF_CYC - 1));
   assign rmii_tick = ref_wrap & ref_lvl;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ref_cnt <= 2'h0;
         ref_lvl <= 1'b0;
      end else if (ref_wrap) begin
         ref_cnt <= 2'h0;
         ref_lvl <= ~ref_lvl;
      end else begin
         ref_cnt <= ref_cnt + 2'h1;
      end
   end

   // ========================================================================
   // RMII receive outputs and reference clock pin.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rxd0_pin_out     <= 1'b0;
         crs_dv_pin_out   <= 1'b0;
         rxer_pin_out     <= 1'b0;
         rxd0_pin_oe_n    <= 1'b1;
         crs_dv_pin_oe_n  <= 1'b1;
         rxer_pin_oe_n    <= 1'b1;
         ref_clk_pin_out  <= 1'b0;
         ref_clk_pin_oe_n <= 1'b1;
      end else begin
         rxd0_pin_oe_n    <= ~run;
         crs_dv_pin_oe_n  <= ~run;
         rxer_pin_oe_n    <= ~run;
         ref_clk_pin_out  <= ref_lvl;
         ref_clk_pin_oe_n <= ~run | clk50_mode;
         if (rmii_tick) begin
            rxd0_pin_out   <= rx_data0;
            crs_dv_pin_out <= rx_crs_dv;
            rxer_pin_out   <= rx_error;
         end
      end
   end

endmodule

`default_nettype wire

/* verification/rsp_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Port-level checks of the strap and pin mux block.
module rsp_top_properties (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        rx_data0,
   input wire logic        rx_crs_dv,
   input wire logic        rx_error,
   input wire logic        rxd0_pin_in,
   input wire logic        rxd0_pin_out,
   input wire logic        rxd0_pin_oe_n,
   input wire logic        crs_dv_pin_in,
   input wire logic        crs_dv_pin_out,
   input wire logic        crs_dv_pin_oe_n,
   input wire logic        ref_clk_pin_in,
   input wire logic        ref_clk_pin_out,
   input wire logic        ref_clk_pin_oe_n,
   input wire logic        rxer_pin_in,
   input wire logic        rxer_pin_out,
   input wire logic        rxer_pin_oe_n,
   input wire logic        interrupt_request_pin_in,
   input wire logic        interrupt_request_pin_out,
   input wire logic        interrupt_request_pin_oe_n,
   input wire logic        wake_sel_pin_in
);
   logic [5:0] strap_exp;
   logic [7:0] rd_addr;

   // Keeps the pin levels seen in reset and the address of the read under way.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strap_exp <= {wake_sel_pin_in, interrupt_request_pin_in, rxer_pin_in,
                       ref_clk_pin_in, crs_dv_pin_in, rxd0_pin_in};
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_PINS_HELD:
   assert property ($fell(sys_rst) |-> (rxd0_pin_oe_n && crs_dv_pin_oe_n && rxer_pin_oe_n
      && ref_clk_pin_oe_n && interrupt_request_pin_oe_n)[*3]) else $error("pin driven early");
   AST_PINS_ON:
   assert property ($fell(sys_rst) |-> ##[3:8] (!rxd0_pin_oe_n && !crs_dv_pin_oe_n
      && !rxer_pin_oe_n)) else $error("receive pins not enabled");
   AST_RXD0:
   assert property ((!rxd0_pin_oe_n && $stable(rx_data0))[*8] |-> rxd0_pin_out == rx_data0)
      else $error("data bit 0 pin wrong");
   AST_CRS_DV:
   assert property ((!crs_dv_pin_oe_n && $stable(rx_crs_dv))[*8] |-> crs_dv_pin_out == rx_crs_dv)
      else $error("carrier sense pin wrong");
   AST_RXER:
   assert property ((!rxer_pin_oe_n && $stable(rx_error))[*8] |-> rxer_pin_out == rx_error)
      else $error("receive error pin wrong");
   AST_REF_CLK:
   assert property ($rose(ref_clk_pin_out) && !ref_clk_pin_oe_n |-> ##1 ref_clk_pin_out
      ##1 (!ref_clk_pin_out)[*2] ##1 ref_clk_pin_out) else $error("reference clock period wrong");
   AST_OPEN_DRAIN:
   assert property (!interrupt_request_pin_out) else $error("shared pin driven high");
   AST_STRAPS:
   assert property (s_axi_rvalid && rd_addr == 8'h00 |-> s_axi_rdata[5:0] == strap_exp
      && s_axi_rdata[9]) else $error("strap readback wrong");
endmodule

bind rsp_top rsp_top_properties u_props (.core_clk, .sys_rst, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .rx_data0, .rx_crs_dv, .rx_error,
   .rxd0_pin_in, .rxd0_pin_out, .rxd0_pin_oe_n, .crs_dv_pin_in, .crs_dv_pin_out,
   .crs_dv_pin_oe_n, .ref_clk_pin_in, .ref_clk_pin_out, .ref_clk_pin_oe_n, .rxer_pin_in,
   .rxer_pin_out, .rxer_pin_oe_n, .interrupt_request_pin_in, .interrupt_request_pin_out,
   .interrupt_request_pin_oe_n, .wake_sel_pin_in);

`default_nettype wire

/* verification/rsp_mac_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Board and MAC side: strap resistors on released pins, sampling on the clock rise.
module rsp_mac_model (
   input  wire logic [4:0] strap,
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe_n,
   output logic      [4:0] pin_lvl,
   output logic      [2:0] rx_seen
);
   // A released pin shows its resistor level, a driven one the driver.
   assign pin_lvl = (strap & pin_oe_n) | (pin_out & ~pin_oe_n);

   // The MAC takes error, carrier sense and data bit 0 on the reference clock rise.
   always @(posedge pin_lvl[2]) begin
      rx_seen <= {pin_lvl[3], pin_lvl[1], pin_lvl[0]};
   end
endmodule

`default_nettype wire

/* verification/rsp_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Self-checking bench of the strap and pin mux block.
module rsp_top_tb;
   typedef struct {logic [7:0] a; logic [31:0] w, m, e; logic [1:0] r;} rsp_row_t;
   logic core_clk, sys_rst, wake_sel_pin_in, rx_data0, rx_crs_dv, rx_error, wol_event, prev;
   logic [7:0] s_axi_awaddr, s_axi_araddr, int_event;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0] strap, p_out, p_oe_n, p_lvl;
   logic [2:0] rx_seen;
   int fails, cmp_count, n;
   rsp_row_t rows[5];

   rsp_top dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data0, .rx_crs_dv, .rx_error,
      .int_event, .wol_event, .rxd0_pin_in(p_lvl[0]), .rxd0_pin_out(p_out[0]),
      .rxd0_pin_oe_n(p_oe_n[0]), .crs_dv_pin_in(p_lvl[1]), .crs_dv_pin_out(p_out[1]),
      .crs_dv_pin_oe_n(p_oe_n[1]), .ref_clk_pin_in(p_lvl[2]), .ref_clk_pin_out(p_out[2]),
      .ref_clk_pin_oe_n(p_oe_n[2]), .rxer_pin_in(p_lvl[3]), .rxer_pin_out(p_out[3]),
      .rxer_pin_oe_n(p_oe_n[3]), .interrupt_request_pin_in(p_lvl[4]),
      .interrupt_request_pin_out(p_out[4]), .interrupt_request_pin_oe_n(p_oe_n[4]),
      .wake_sel_pin_in);
   rsp_mac_model mac (.strap, .pin_out(p_out), .pin_oe_n(p_oe_n), .pin_lvl(p_lvl), .rx_seen);

   // Clock at 200 MHz and a watchdog well beyond the expected run.
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      summarize();
   end

   // ==========================================================================
   // Shared tasks.
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         k++;
      end while (!s_axi_bvalid && k < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (k >= 200) fails++;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         k++;
      end while (!s_axi_rvalid && k < 200);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (k >= 200) fails++;
   endtask
   task automatic do_reset(input logic [5:0] s);
      @(posedge core_clk);
      strap <= s[4:0];
      wake_sel_pin_in <= s[5];
      sys_rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic pulse(input logic [7:0] e, input logic w);
      @(posedge core_clk);
      int_event <= e;
      wol_event <= w;
      @(posedge core_clk);
      int_event <= 8'h00;
      wol_event <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   // ==========================================================================
   // Main sequence.
   initial begin
      rows = '{'{8'h04, 32'h0, 32'h1, 32'h0, 2'b00}, '{8'h7c, 32'h200, 32'h200, 32'h200, 2'b00},
               '{8'h7c, 32'h0, 32'h200, 32'h0, 2'b00}, '{8'h6c, 32'hff00, 32'hff00, 32'hff00, 2'b00},
               '{8'h40, 32'h1, 32'hffffffff, 32'h0, 2'b10}};
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rx_data0, rx_crs_dv, rx_error, wol_event, int_event, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      strap = 5'h1f;
      wake_sel_pin_in = 1'b0;
      do_reset(6'b010101);
      axi_rd(8'h00, rd, rsp);
      chk("strap", rd & 32'h33f, 32'h215);
      chk("pin_oe_n", 32'(p_oe_n), 32'h10);
      $display("test reset done");
      foreach (rows[i]) begin
         axi_wr(rows[i].a, rows[i].w, rsp);
         chk("bresp", 32'(rsp), 32'(rows[i].r));
         axi_rd(rows[i].a, rd, rsp);
         chk("rresp", 32'(rsp), 32'(rows[i].r));
         chk("rdata", rd & rows[i].m, rows[i].e);
      end
      $display("test registers done");
      for (int v = 0; v < 8; v++) begin
         @(posedge core_clk);
         {rx_error, rx_crs_dv, rx_data0} <= 3'(v);
         repeat (12) @(posedge core_clk);
         chk("rx_pins", 32'({p_out[3], p_out[1], p_out[0]}), 32'(v));
         chk("mac_seen", 32'(rx_seen), 32'(v));
      end
      n = 0;
      prev = p_lvl[2];
      repeat (40) begin
         @(posedge core_clk);
         if (p_lvl[2] && !prev) n++;
         prev = p_lvl[2];
      end
      chk("ref_rises", 32'(n), 32'd10);
      axi_wr(8'h04, 32'h1, rsp);
      repeat (3) @(posedge core_clk);
      chk("ref_oe_n", 32'(p_oe_n[2]), 32'h1);
      axi_wr(8'h04, 32'h0, rsp);
      $display("test rmii done");
      pulse(8'h04, 1'b0);
      chk("irq_oe_n", 32'(p_oe_n[4]), 32'h0);
      axi_rd(8'h6c, rd, rsp);
      chk("int_status", 32'(rd[7:0]), 32'h04);
      repeat (3) @(posedge core_clk);
      chk("irq_oe_n", 32'(p_oe_n[4]), 32'h1);
      axi_wr(8'h7c, 32'h200, rsp);
      repeat (3) @(posedge core_clk);
      chk("irq_oe_n", 32'(p_oe_n[4]), 32'h0);
      pulse(8'h80, 1'b0);
      chk("irq_oe_n", 32'(p_oe_n[4]), 32'h1);
      axi_rd(8'h6c, rd, rsp);
      chk("int_status", 32'(rd[7:0]), 32'h80);
      axi_wr(8'h7c, 32'h0, rsp);
      axi_wr(8'h6c, 32'h0, rsp);
      pulse(8'h01, 1'b0);
      chk("irq_masked", 32'(p_oe_n[4]), 32'h1);
      axi_rd(8'h6c, rd, rsp);
      chk("int_status", 32'(rd[7:0]), 32'h01);
      $display("test interrupt done");
      do_reset(6'b101010);
      wake_sel_pin_in <= 1'b0;
      strap <= 5'b10101;
      axi_rd(8'h00, rd, rsp);
      chk("strap", rd & 32'h33f, 32'h22a);
      pulse(8'h00, 1'b1);
      chk("wake_oe_n", 32'(p_oe_n[4]), 32'h0);
      axi_rd(8'h00, rd, rsp);
      chk("wake_flag", rd & 32'h33f, 32'h32a);
      axi_wr(8'h00, 32'h100, rsp);
      repeat (3) @(posedge core_clk);
      chk("wake_oe_n", 32'(p_oe_n[4]), 32'h1);
      $display("test wake done");
      summarize();
   end
endmodule

`default_nettype wire
